// ==== shared/mmeu_cfg.svh ====
// Register offsets, field positions, widths and saturation limits of the move and multiply unit.
`ifndef MMEU_CFG_SVH
`define MMEU_CFG_SVH

// Byte offsets of the control registers on the register bus.
`define MMEU_OFF_CMD 8'h00
`define MMEU_OFF_LIT 8'h04
`define MMEU_OFF_STAT 8'h08
`define MMEU_OFF_PF 8'h0C
`define MMEU_OFF_PAGE 8'h10
`define MMEU_OFF_TBL 8'h14
`define MMEU_OFF_ACCA_LO 8'h18
`define MMEU_OFF_ACCA_HI 8'h1C
`define MMEU_OFF_ACCB_LO 8'h20
`define MMEU_OFF_ACCB_HI 8'h24

// Address bits 7:6 select the working register window and the data memory window.
`define MMEU_W_REGION 2'h1
`define MMEU_MEM_REGION 2'h2

// Status register bit positions.
`define MMEU_ST_OVF_A 0
`define MMEU_ST_OVF_B 1
`define MMEU_ST_OVF_ANY 2
`define MMEU_ST_SAT_A 3
`define MMEU_ST_SAT_B 4
`define MMEU_ST_SAT_ANY 5

// Page register widths and the position of the write page in the page register.
`define MMEU_RDPAG_W 10
`define MMEU_WRPAG_W 9
`define MMEU_TBLPG_W 8
`define MMEU_WRPAG_LSB 16

// Widths of the short literal and of the accumulators.
`define MMEU_LIT5_W 5
`define MMEU_ACC_W 40

// Saturation limits of a 40-bit accumulator.
`define MMEU_ACC_MAX 40'h7F_FFFF_FFFF
`define MMEU_ACC_MIN 40'h80_0000_0000

`endif

// ==== shared/mmeu_pkg.sv ====
// Types shared by the move and multiply unit: operations, command layout, states.
package mmeu_pkg;

	// Operation codes, numbered 0 upward in this order.
	typedef enum logic [4:0] {
		OP_NOP, OP_LIT16, OP_LIT8, OP_DW_STORE, OP_DW_LOAD,
		OP_PAG_LIT_RD, OP_PAG_LIT_WR, OP_PAG_LIT_TBL,
		OP_PAGW_RD, OP_PAGW_WR, OP_PAGW_TBL, OP_PF_STORE,
		OP_DSP_MUL, OP_DSP_SQR, OP_DSP_NEG, OP_DSP_SUB,
		OP_MUL_PAIR, OP_MUL_NARROW, OP_MUL_LIT_PAIR, OP_MUL_LIT_NARROW,
		OP_MUL_ACC, OP_MUL_LIT_ACC
	} mmeu_op_t;

	// Command word: operation, accumulator, operand signs, register fields.
	typedef struct packed {
		logic [9:0] pad;
		logic [3:0] rd;
		logic [3:0] rb;
		logic [3:0] ra;
		logic periph;
		logic wback;
		logic b_signed;
		logic a_signed;
		logic acc_b;
		mmeu_op_t op;
	} mmeu_cmd_t;

	// Prefetch word: pointer and destination registers for both operand paths.
	typedef struct packed {
		logic [13:0] pad;
		logic en_y;
		logic en_x;
		logic [3:0] wyd;
		logic [3:0] wy;
		logic [3:0] wxd;
		logic [3:0] wx;
	} mmeu_pf_t;

	// Avalon-MM request from the master.
	typedef struct packed {
		logic [7:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} mmeu_avs_req_t;

	// Accumulator flags.
	typedef struct packed {
		logic ovf_a;
		logic ovf_b;
		logic sat_a;
		logic sat_b;
	} mmeu_flags_t;

	// Execution states, Gray coded along idle, first, second, extra.
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_EXEC = 2'h1,
		ST_EXEC2 = 2'h3,
		ST_EXTRA = 2'h2
	} mmeu_state_t;

endpackage

// ==== verilog/mmeu_mul.sv ====
// Combinational multiplier with independent signedness for each operand.
`timescale 1ns/1ps
module mmeu_mul #(
	parameter int W = 16
) (
	input wire logic [W-1:0] a,
	input wire logic [W-1:0] b,
	input wire logic a_signed,
	input wire logic b_signed,
	output logic [2*W:0] prod
);
	// Operands widened by one bit so that signed and unsigned share one array.
	logic signed [W:0] ax;
	logic signed [W:0] bx;
	logic signed [2*W+1:0] full;

	// A signed operand repeats its top bit, an unsigned one gets a zero.
	assign ax = {a_signed & a[W-1], a};
	assign bx = {b_signed & b[W-1], b};
	assign full = ax * bx;
	// The product always fits in one bit more than twice the operand width.
	assign prod = full[2*W:0];
endmodule

// ==== verilog/mmeu_top.sv ====
// Move and multiply execution unit with its Avalon-MM register slave.
// Operation
// - 16-bit literal to register, one cycle, no flags.
// - 8-bit literal to register, one cycle, no flags.
// - Store even register pair, two cycles.
// - Load word pair into register pair, two cycles.
// - 10-bit literal into read page register.
// - 9-bit literal into write page register.
// - 8-bit literal into table page register.
// - Register low bits into page registers.
// - Prefetch and optional other accumulator write-back.
// - Multiply to accumulator, update overflow; saturation flags kept.
// - Square to accumulator, same flags.
// - Negated product to accumulator, flags untouched.
// - Subtract product from accumulator, update flags.
// - Signed product to register pair, one cycle.
// - Mixed sign multiplies honour each operand sign.
// - Narrow multiply writes one register only.
// - Short literal zero-extended, pair or single result.
// - Integer multiply into accumulator, no flags.
// - Accumulator literal multiply uses unsigned operands.
// - Peripheral register reads cost one extra cycle.
//
// The Avalon-MM interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "mmeu_cfg.svh"
module mmeu_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire mmeu_pkg::mmeu_avs_req_t avs_req,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	import mmeu_pkg::*;

	// Working registers, data memory and accumulators.
	logic [15:0] w [16];
	logic [15:0] next_w [16];
	logic [15:0] mem [16];
	logic [15:0] next_mem [16];
	logic [`MMEU_ACC_W-1:0] acc [2];
	logic [`MMEU_ACC_W-1:0] next_acc [2];

	// Page registers.
	logic [`MMEU_RDPAG_W-1:0] rdpag;
	logic [`MMEU_RDPAG_W-1:0] next_rdpag;
	logic [`MMEU_WRPAG_W-1:0] wrpag;
	logic [`MMEU_WRPAG_W-1:0] next_wrpag;
	logic [`MMEU_TBLPG_W-1:0] tblpg;
	logic [`MMEU_TBLPG_W-1:0] next_tblpg;

	// Command, literal, prefetch set-up and flags.
	mmeu_cmd_t cmd;
	mmeu_cmd_t next_cmd;
	logic [15:0] lit;
	logic [15:0] next_lit;
	mmeu_pf_t pf;
	mmeu_pf_t next_pf;
	mmeu_flags_t flags;
	mmeu_flags_t next_flags;

	// Sequencer and bus handshake.
	mmeu_state_t state;
	mmeu_state_t next_state;
	logic next_waitrequest;
	logic [31:0] next_readdata;

	// Multiplier operands and product.
	logic [15:0] op_a;
	logic [15:0] op_b;
	logic sgn_a;
	logic sgn_b;
	logic [32:0] prod;
	logic [`MMEU_ACC_W-1:0] prod40;

	// Decoded command properties.
	logic is_dsp;
	logic uses_lit;
	logic reads_mem;
	logic [3:0] ptr;
	logic [3:0] ptr_next;
	logic [3:0] rd_next;
	logic [3:0] rb_even;
	logic bus_req;

	// Merges a write into a word, lane by lane.
	function automatic logic [31:0] be_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0] be
	);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return r;
	endfunction

	// Command decode shared by the operand path and the sequencer.
	always_comb begin
		is_dsp = (cmd.op == OP_DSP_MUL) || (cmd.op == OP_DSP_SQR) ||
			(cmd.op == OP_DSP_NEG) || (cmd.op == OP_DSP_SUB);
		uses_lit = (cmd.op == OP_MUL_LIT_PAIR) || (cmd.op == OP_MUL_LIT_NARROW) ||
			(cmd.op == OP_MUL_LIT_ACC);
		// Only operations that fetch from data memory pay the peripheral penalty.
		reads_mem = (cmd.op == OP_DW_LOAD) || (((cmd.op == OP_PF_STORE) || is_dsp) &&
			(pf.en_x || pf.en_y));
		ptr = w[cmd.ra][3:0];
		ptr_next = 4'(ptr + 4'h1);
		rd_next = 4'(cmd.rd + 4'h1);
		rb_even = {cmd.rb[3:1], 1'b0};
		bus_req = avs_req.read || avs_req.write;
	end

	// Operand selection; the DSP forms are always signed by signed.
	always_comb begin
		op_a = w[cmd.ra];
		if (uses_lit) begin
			op_b = {11'h000, lit[`MMEU_LIT5_W-1:0]};
		end else if (cmd.op == OP_DSP_SQR) begin
			op_b = w[cmd.ra];
		end else begin
			op_b = w[cmd.rb];
		end
		if (is_dsp) begin
			sgn_a = 1'b1;
			sgn_b = 1'b1;
		end else if (cmd.op == OP_MUL_LIT_ACC) begin
			sgn_a = 1'b0;
			sgn_b = 1'b0;
		end else begin
			sgn_a = cmd.a_signed;
			sgn_b = cmd.b_signed & ~uses_lit;
		end
	end

	// One shared multiplier serves every multiply form.
	mmeu_mul #(
		.W(16)
	) u_mul (
		.a(op_a),
		.b(op_b),
		.a_signed(sgn_a),
		.b_signed(sgn_b),
		.prod(prod)
	);

	// The 33-bit product is sign extended into accumulator width.
	assign prod40 = {{7{prod[32]}}, prod};

	// Next-state logic for the bus slave, the registers and the sequencer.
	always_comb begin
		logic [31:0] mrg;
		logic [`MMEU_ACC_W-1:0] cur;
		logic [`MMEU_ACC_W-1:0] res;
		logic ovf;
		logic cat;
		logic sel;
		mrg = 32'h0000_0000;
		cur = acc[cmd.acc_b];
		res = prod40;
		ovf = 1'b0;
		cat = 1'b0;
		sel = cmd.acc_b;
		next_w = w;
		next_mem = mem;
		next_acc = acc;
		next_rdpag = rdpag;
		next_wrpag = wrpag;
		next_tblpg = tblpg;
		next_cmd = cmd;
		next_lit = lit;
		next_pf = pf;
		next_flags = flags;
		next_state = state;
		next_waitrequest = 1'b1;
		next_readdata = avs_readdata;

		// Bus requests are served only while idle, so they never race execution.
		if (bus_req && state == ST_IDLE) begin
			if (avs_waitrequest) begin
				// First cycle of a request: present data and drop waitrequest.
				next_waitrequest = 1'b0;
				next_readdata = 32'h0000_0000;
				case (avs_req.address)
					`MMEU_OFF_CMD: next_readdata = cmd;
					`MMEU_OFF_LIT: next_readdata = {16'h0000, lit};
					`MMEU_OFF_STAT: begin
						next_readdata[`MMEU_ST_OVF_A] = flags.ovf_a;
						next_readdata[`MMEU_ST_OVF_B] = flags.ovf_b;
						next_readdata[`MMEU_ST_OVF_ANY] = flags.ovf_a | flags.ovf_b;
						next_readdata[`MMEU_ST_SAT_A] = flags.sat_a;
						next_readdata[`MMEU_ST_SAT_B] = flags.sat_b;
						next_readdata[`MMEU_ST_SAT_ANY] = flags.sat_a | flags.sat_b;
					end
					`MMEU_OFF_PF: next_readdata = pf;
					`MMEU_OFF_PAGE: begin
						next_readdata[`MMEU_RDPAG_W-1:0] = rdpag;
						next_readdata[`MMEU_WRPAG_LSB +: `MMEU_WRPAG_W] = wrpag;
					end
					`MMEU_OFF_TBL: next_readdata[`MMEU_TBLPG_W-1:0] = tblpg;
					`MMEU_OFF_ACCA_LO: next_readdata = acc[0][31:0];
					`MMEU_OFF_ACCA_HI: next_readdata[7:0] = acc[0][39:32];
					`MMEU_OFF_ACCB_LO: next_readdata = acc[1][31:0];
					`MMEU_OFF_ACCB_HI: next_readdata[7:0] = acc[1][39:32];
					default: begin
						// Register and memory windows; anything else reads zero.
						if (avs_req.address[7:6] == `MMEU_W_REGION) begin
							next_readdata[15:0] = w[avs_req.address[5:2]];
						end else if (avs_req.address[7:6] == `MMEU_MEM_REGION) begin
							next_readdata[15:0] = mem[avs_req.address[5:2]];
						end
					end
				endcase
			end else if (avs_req.write) begin
				// Handshake edge: the write takes effect here and nowhere else.
				case (avs_req.address)
					`MMEU_OFF_CMD: begin
						// Writing a command starts its execution.
						next_cmd = be_merge(cmd, avs_req.writedata, avs_req.byteenable);
						next_state = ST_EXEC;
					end
					`MMEU_OFF_LIT: begin
						mrg = be_merge({16'h0000, lit}, avs_req.writedata, avs_req.byteenable);
						next_lit = mrg[15:0];
					end
					`MMEU_OFF_STAT: begin
						// Saturation flags clear on a one; overflow follows the last multiply, square or subtract.
						mrg = be_merge(32'h0000_0000, avs_req.writedata, avs_req.byteenable);
						next_flags.sat_a = flags.sat_a & ~mrg[`MMEU_ST_SAT_A];
						next_flags.sat_b = flags.sat_b & ~mrg[`MMEU_ST_SAT_B];
					end
					`MMEU_OFF_PF: next_pf = be_merge(pf, avs_req.writedata, avs_req.byteenable);
					`MMEU_OFF_ACCA_LO: begin
						next_acc[0][31:0] = be_merge(acc[0][31:0], avs_req.writedata,
							avs_req.byteenable);
					end
					`MMEU_OFF_ACCA_HI: begin
						if (avs_req.byteenable[0]) begin
							next_acc[0][39:32] = avs_req.writedata[7:0];
						end
					end
					`MMEU_OFF_ACCB_LO: begin
						next_acc[1][31:0] = be_merge(acc[1][31:0], avs_req.writedata,
							avs_req.byteenable);
					end
					`MMEU_OFF_ACCB_HI: begin
						if (avs_req.byteenable[0]) begin
							next_acc[1][39:32] = avs_req.writedata[7:0];
						end
					end
					default: begin
						// Page registers change only through instructions.
						mrg = be_merge(32'h0000_0000, avs_req.writedata, avs_req.byteenable);
						if (avs_req.address[7:6] == `MMEU_W_REGION) begin
							mrg = be_merge({16'h0000, w[avs_req.address[5:2]]},
								avs_req.writedata, avs_req.byteenable);
							next_w[avs_req.address[5:2]] = mrg[15:0];
						end else if (avs_req.address[7:6] == `MMEU_MEM_REGION) begin
							mrg = be_merge({16'h0000, mem[avs_req.address[5:2]]},
								avs_req.writedata, avs_req.byteenable);
							next_mem[avs_req.address[5:2]] = mrg[15:0];
						end
					end
				endcase
			end
		end

		// Sequencer: first cycle does every single-cycle operation.
		case (state)
			ST_IDLE: begin
				next_state = next_state;
			end
			ST_EXEC: begin
				case (cmd.op)
					OP_LIT16: next_w[cmd.rd] = lit;
					OP_LIT8: next_w[cmd.rd][7:0] = lit[7:0];
					OP_DW_STORE: next_mem[ptr] = w[rb_even];
					OP_DW_LOAD: next_w[cmd.rd] = mem[ptr];
					OP_PAG_LIT_RD: next_rdpag = lit[`MMEU_RDPAG_W-1:0];
					OP_PAG_LIT_WR: next_wrpag = lit[`MMEU_WRPAG_W-1:0];
					OP_PAG_LIT_TBL: next_tblpg = lit[`MMEU_TBLPG_W-1:0];
					OP_PAGW_RD: next_rdpag = w[cmd.ra][`MMEU_RDPAG_W-1:0];
					OP_PAGW_WR: next_wrpag = w[cmd.ra][`MMEU_WRPAG_W-1:0];
					OP_PAGW_TBL: next_tblpg = w[cmd.ra][`MMEU_TBLPG_W-1:0];
					OP_DSP_MUL, OP_DSP_SQR, OP_DSP_SUB: begin
						if (cmd.op == OP_DSP_SUB) begin
							// Catastrophic overflow: operand signs differ, result sign flips.
							res = cur - prod40;
							cat = (cur[39] != prod40[39]) && (res[39] != cur[39]);
							if (cat) begin
								res = cur[39] ? `MMEU_ACC_MIN : `MMEU_ACC_MAX;
							end
						end
						// Overflow means the guard bits no longer copy bit 31.
						ovf = !((&res[39:31]) || !(|res[39:31]));
						next_acc[sel] = res;
						if (sel) begin
							next_flags.ovf_b = ovf;
							next_flags.sat_b = flags.sat_b | cat;
						end else begin
							next_flags.ovf_a = ovf;
							next_flags.sat_a = flags.sat_a | cat;
						end
					end
					OP_DSP_NEG: next_acc[sel] = 40'(-prod40);
					OP_MUL_PAIR, OP_MUL_LIT_PAIR: begin
						next_w[cmd.rd] = prod[15:0];
						next_w[rd_next] = prod[31:16];
					end
					OP_MUL_NARROW, OP_MUL_LIT_NARROW: next_w[cmd.rd] = prod[15:0];
					OP_MUL_ACC, OP_MUL_LIT_ACC: next_acc[sel] = prod40;
					default: next_w = next_w;
				endcase
				// DSP forms and the prefetch-and-store share the operand prefetch.
				if (is_dsp || cmd.op == OP_PF_STORE) begin
					if (pf.en_x) begin
						next_w[pf.wxd] = mem[w[pf.wx][3:0]];
					end
					if (pf.en_y) begin
						next_w[pf.wyd] = mem[w[pf.wy][3:0]];
					end
				end
				// Write-back stores the other accumulator's upper word; it wins last.
				if (cmd.wback && (cmd.op == OP_PF_STORE || cmd.op == OP_DSP_SUB)) begin
					next_w[cmd.rd] = acc[~sel][31:16];
				end
				if (cmd.op == OP_DW_STORE || cmd.op == OP_DW_LOAD) begin
					next_state = ST_EXEC2;
				end else if (cmd.periph && reads_mem) begin
					next_state = ST_EXTRA;
				end else begin
					next_state = ST_IDLE;
				end
			end
			ST_EXEC2: begin
				// Second word of a double move: odd register or next address.
				if (cmd.op == OP_DW_STORE) begin
					next_mem[ptr_next] = w[{rb_even[3:1], 1'b1}];
				end else begin
					next_w[rd_next] = mem[ptr_next];
				end
				next_state = (cmd.periph && reads_mem) ? ST_EXTRA : ST_IDLE;
			end
			ST_EXTRA: begin
				// Peripheral access stall: nothing changes, the bus waits.
				next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// Registers of the unit; memories clear at reset so reads are defined.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 16; i++) begin
				w[i] <= 16'h0000;
				mem[i] <= 16'h0000;
			end
			acc[0] <= 40'h00_0000_0000;
			acc[1] <= 40'h00_0000_0000;
			rdpag <= 10'h001;
			wrpag <= 9'h001;
			tblpg <= 8'h00;
			cmd <= 32'h0000_0000;
			lit <= 16'h0000;
			pf <= 32'h0000_0000;
			flags <= 4'h0;
			state <= ST_IDLE;
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else begin
			w <= next_w;
			mem <= next_mem;
			acc <= next_acc;
			rdpag <= next_rdpag;
			wrpag <= next_wrpag;
			tblpg <= next_tblpg;
			cmd <= next_cmd;
			lit <= next_lit;
			pf <= next_pf;
			flags <= next_flags;
			state <= next_state;
			avs_waitrequest <= next_waitrequest;
			avs_readdata <= next_readdata;
		end
	end
endmodule

// ==== testbench/mmeu_top_properties.sv ====
// Assertions on the register bus ports of the move and multiply unit.
`timescale 1ns/1ps
module mmeu_top_properties (
	input wire logic clk,
	input wire logic rst_n,
	input wire mmeu_pkg::mmeu_avs_req_t avs_req,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	import mmeu_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	logic rdone; // A read completes in this cycle.
	mmeu_cmd_t wc; // Write data seen as a command word.
	assign rdone = avs_req.read && !avs_waitrequest;
	assign wc = mmeu_cmd_t'(avs_req.writedata);
	// A command write is accepted.
	sequence cmd_go;
		avs_req.write && !avs_waitrequest && avs_req.address == 8'h00;
	endsequence
	// A double move keeps the bus stalled while both words move; a single op stalls only two.
	sequence pair_busy;
		avs_waitrequest [*3];
	endsequence
	// A peripheral operand adds one more stalled cycle after the two words.
	sequence periph_busy;
		avs_waitrequest [*4];
	endsequence
	ack_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("ack longer than one cycle");
	ack_req_a: assert property (!avs_waitrequest |-> avs_req.read || avs_req.write)
		else $error("ack without request");
	ack_bound_a: assert property ((avs_req.read || avs_req.write) && avs_waitrequest
		|-> ##[1:6] !avs_waitrequest) else $error("request not answered");
	pair_stall_a: assert property (cmd_go ##0 (wc.op inside {OP_DW_STORE, OP_DW_LOAD})
		|=> pair_busy) else $error("double move too short");
	periph_extra_a: assert property (cmd_go ##0 (wc.op == OP_DW_LOAD && wc.periph)
		|=> periph_busy) else $error("no extra cycle");
	stat_or_a: assert property (rdone && avs_req.address == 8'h08 |->
		avs_readdata[31:6] == 0
		&& avs_readdata[2] == (avs_readdata[0] | avs_readdata[1])
		&& avs_readdata[5] == (avs_readdata[3] | avs_readdata[4])) else $error("status");
	page_width_a: assert property (rdone && avs_req.address == 8'h10 |->
		avs_readdata[15:10] == 0 && avs_readdata[31:25] == 0) else $error("page");
	tbl_width_a: assert property (rdone && avs_req.address == 8'h14 |->
		avs_readdata[31:8] == 0) else $error("table page");
	w_width_a: assert property (rdone && avs_req.address[7:6] == 2'h1 |->
		avs_readdata[31:16] == 0) else $error("working register");
endmodule

// ==== testbench/mmeu_master.sv ====
// Bus master model standing in for the decoder in front of the unit.
`timescale 1ns/1ps
module mmeu_master (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic go,
	input wire logic rd,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic avs_waitrequest,
	output mmeu_pkg::mmeu_avs_req_t avs_req,
	output logic done
);
	import mmeu_pkg::*;
	mmeu_avs_req_t next_req; // Request for the next cycle.
	// Done marks the cycle in which the slave answers.
	assign done = (avs_req.read || avs_req.write) && !avs_waitrequest;
	// Hold the request until answered; released address and data show inverted values, not stale ones.
	always_comb begin
		next_req = avs_req;
		if (done) begin
			next_req.read = 1'b0;
			next_req.write = 1'b0;
			next_req.address = ~avs_req.address;
			next_req.writedata = ~avs_req.writedata;
		end else if (go && !avs_req.read && !avs_req.write) begin
			next_req = '{address: addr, read: rd, write: !rd, writedata: wdata, byteenable: 4'hF};
		end
	end
	// The request only changes just after a rising edge.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_req <= '0;
		end else begin
			avs_req <= next_req;
		end
	end
endmodule

// ==== testbench/mmeu_top_tb.sv ====
// Self-checking bench for the move and multiply unit.
`timescale 1ns/1ps
`include "mmeu_cfg.svh"
module mmeu_top_tb;
	import mmeu_pkg::*;
	logic clk, rst_n, go, rdn, done, wreq;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, seed;
	logic [15:0] a;
	logic [39:0] p, q, u, e;
	logic [39:0] expq[$]; // Address and expected read data, oldest first.
	mmeu_avs_req_t req;
	int err_count = 0;
	int num_checks = 0;
	mmeu_top i_dut (.clk(clk), .rst_n(rst_n), .avs_req(req), .avs_readdata(rdata),
		.avs_waitrequest(wreq));
	mmeu_master i_master (.clk(clk), .rst_n(rst_n), .go(go), .rd(rdn), .addr(addr),
		.wdata(wdata), .avs_waitrequest(wreq), .avs_req(req), .done(done));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Next value of the stimulus generator.
	function automatic logic [31:0] lf(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Reference product, extended to accumulator width.
	function automatic logic [39:0] mul(logic [15:0] x, logic [15:0] y, logic sx, logic sy);
		logic signed [33:0] r;
		r = $signed({sx & x[15], x}) * $signed({sy & y[15], y});
		return {{6{r[33]}}, r};
	endfunction
	// Command word; f holds peripheral, write-back, b sign, a sign and accumulator select.
	function automatic logic [31:0] mk(mmeu_op_t o, logic [3:0] ra, logic [3:0] rb,
		logic [3:0] rd, logic [4:0] f);
		mmeu_cmd_t c;
		c = '0;
		c.op = o;
		c.ra = ra;
		c.rb = rb;
		c.rd = rd;
		{c.periph, c.wback, c.b_signed, c.a_signed, c.acc_b} = f;
		return c;
	endfunction
	function automatic logic [7:0] wa(logic [3:0] n);
		return {2'h1, n, 2'h0};
	endfunction
	task automatic results();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// One bus access through the master; the wait is bounded.
	task automatic acc(input logic r, input logic [7:0] ad, input logic [31:0] d);
		int n;
		go <= 1'b1;
		rdn <= r;
		addr <= ad;
		wdata <= d;
		@(posedge clk);
		go <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (done !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_count++;
			$display("mismatch handshake expected 1 seen 0");
			results();
		end
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		acc(1'b0, ad, d);
	endtask
	task automatic rd(input logic [7:0] ad, input logic [31:0] x);
		expq.push_back({ad, x});
		acc(1'b1, ad, 32'h0);
	endtask
	// Every completed read takes the oldest expectation.
	always @(posedge clk) begin
		if (req.read && wreq === 1'b0 && expq.size() > 0) begin
			e = expq.pop_front();
			num_checks++;
			if (rdata !== e[31:0]) begin
				err_count++;
				$display("mismatch read %h expected %h seen %h", e[39:32], e[31:0], rdata);
			end
		end
	end
	initial begin
		go = 1'b0;
		rdn = 1'b0;
		addr = 8'h0;
		wdata = 32'h0;
		rst_n = 1'b0;
		seed = 32'h0001_4BE5;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(`MMEU_OFF_PAGE, 32'h0001_0001);
		wr(8'h28, 32'hFFFF_FFFF);
		rd(8'h28, 32'h0); // Unmapped offsets read zero.
		wr(`MMEU_OFF_LIT, 32'h0000_A5C3);
		wr(`MMEU_OFF_CMD, mk(OP_LIT16, 0, 0, 3, 0));
		rd(wa(3), 32'hA5C3);
		wr(`MMEU_OFF_LIT, 32'h0000_FF7E);
		wr(`MMEU_OFF_CMD, mk(OP_LIT8, 0, 0, 3, 0));
		rd(wa(3), 32'hA57E);
		wr(`MMEU_OFF_LIT, 32'h0000_FFFF);
		for (int k = 0; k < 3; k++) wr(`MMEU_OFF_CMD, mk(mmeu_op_t'(5 + k), 0, 0, 0, 0));
		rd(`MMEU_OFF_PAGE, 32'h01FF_03FF);
		rd(`MMEU_OFF_TBL, 32'hFF);
		wr(wa(5), 32'hFEA6);
		for (int k = 0; k < 3; k++) wr(`MMEU_OFF_CMD, mk(mmeu_op_t'(8 + k), 5, 5, 5, 0));
		wr(`MMEU_OFF_PAGE, 32'h0);
		rd(`MMEU_OFF_PAGE, 32'h00A6_02A6);
		rd(`MMEU_OFF_TBL, 32'hA6);
		wr(wa(9), 32'h5A5A);
		// Each sign pairing with a negative first operand, where signedness matters.
		for (logic [2:0] i = 0; i < 4; i++) begin
			seed = lf(seed);
			a = seed[15:0] | 16'h8000;
			seed = lf(seed);
			p = mul(a, seed[15:0], i[0], i[1]);
			wr(wa(1), {16'h0, a});
			wr(wa(2), {16'h0, seed[15:0]});
			wr(`MMEU_OFF_LIT, {16'h0, seed[31:16]});
			wr(`MMEU_OFF_CMD, mk(OP_MUL_PAIR, 1, 2, 6, {2'h0, i[1:0], 1'b0}));
			rd(wa(6), p[15:0]);
			rd(wa(7), p[31:16]);
			wr(`MMEU_OFF_CMD, mk(OP_MUL_NARROW, 1, 2, 8, {2'h0, i[1:0], 1'b0}));
			rd(wa(8), p[15:0]);
			rd(wa(9), 32'h5A5A);
			wr(`MMEU_OFF_CMD, mk(OP_MUL_ACC, 1, 2, 0, {2'h0, i[1:0], i[0]}));
			rd(i[0] ? `MMEU_OFF_ACCB_LO : `MMEU_OFF_ACCA_LO, p[31:0]);
			rd(i[0] ? `MMEU_OFF_ACCB_HI : `MMEU_OFF_ACCA_HI, p[39:32]);
			q = mul(a, {11'h0, seed[20:16]}, i[0], 1'b0);
			u = mul(a, {11'h0, seed[20:16]}, 1'b0, 1'b0);
			wr(`MMEU_OFF_CMD, mk(OP_MUL_LIT_PAIR, 1, 0, 6, {3'h0, i[0], 1'b0}));
			rd(wa(6), q[15:0]);
			rd(wa(7), q[31:16]);
			wr(`MMEU_OFF_CMD, mk(OP_MUL_LIT_NARROW, 1, 0, 8, {3'h0, i[0], 1'b0}));
			rd(wa(8), q[15:0]);
			wr(`MMEU_OFF_CMD, mk(OP_MUL_LIT_ACC, 1, 0, 0, {4'h1, 1'b0}));
			rd(`MMEU_OFF_ACCA_LO, u[31:0]);
		end
		// Accumulator flags: overflow set, kept, cleared, then saturation.
		wr(wa(1), 32'h8000);
		wr(wa(2), 32'h4000);
		wr(`MMEU_OFF_ACCA_LO, 32'h7FFF_FFFF);
		wr(`MMEU_OFF_ACCA_HI, 32'h0);
		wr(`MMEU_OFF_CMD, mk(OP_DSP_SUB, 1, 2, 0, 0));
		rd(`MMEU_OFF_ACCA_LO, 32'h9FFF_FFFF);
		rd(`MMEU_OFF_STAT, 32'h05);
		wr(`MMEU_OFF_CMD, mk(OP_DSP_NEG, 1, 2, 0, 0));
		rd(`MMEU_OFF_ACCA_LO, 32'h2000_0000);
		rd(`MMEU_OFF_STAT, 32'h05);
		wr(`MMEU_OFF_CMD, mk(OP_DSP_MUL, 1, 2, 0, 0));
		rd(`MMEU_OFF_ACCA_HI, 32'hFF);
		rd(`MMEU_OFF_STAT, 32'h0);
		wr(`MMEU_OFF_CMD, mk(OP_DSP_SQR, 1, 0, 0, 5'h01));
		rd(`MMEU_OFF_ACCB_LO, 32'h4000_0000);
		wr(`MMEU_OFF_ACCB_LO, 32'hFFFF_FFFF);
		wr(`MMEU_OFF_ACCB_HI, 32'h7F);
		wr(`MMEU_OFF_CMD, mk(OP_DSP_SUB, 1, 2, 10, 5'h09));
		rd(`MMEU_OFF_ACCB_HI, 32'h7F);
		rd(`MMEU_OFF_STAT, 32'h36);
		rd(wa(10), 32'hE000);
		wr(`MMEU_OFF_STAT, 32'h10);
		rd(`MMEU_OFF_STAT, 32'h06);
		// Prefetch both paths from memory, then write back the other accumulator.
		wr(8'h8C, 32'h1111);
		wr(8'h90, 32'h2222);
		wr(wa(11), 32'h3);
		wr(wa(12), 32'h4);
		wr(`MMEU_OFF_PF, 32'h0003_ECDB);
		wr(`MMEU_OFF_CMD, mk(OP_PF_STORE, 0, 0, 15, 5'h18));
		rd(wa(13), 32'h1111);
		rd(wa(14), 32'h2222);
		rd(wa(15), 32'hFFFF);
		rd(`MMEU_OFF_STAT, 32'h06);
		wr(wa(2), 32'h1357);
		wr(wa(3), 32'h2468);
		wr(wa(4), 32'h6);
		wr(`MMEU_OFF_CMD, mk(OP_DW_STORE, 4, 3, 0, 0));
		rd(8'h98, 32'h1357);
		rd(8'h9C, 32'h2468);
		wr(`MMEU_OFF_CMD, mk(OP_DW_LOAD, 4, 0, 9, 5'h10));
		rd(wa(9), 32'h1357);
		rd(wa(10), 32'h2468);
		results();
	end
endmodule
bind mmeu_top mmeu_top_properties i_props (.clk(clk), .rst_n(rst_n), .avs_req(avs_req),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
